// ### inc/rsc_pkg.sv
// Constants, types and register map of the reset and start-up controller
// =====================================================================
// Overview of operation
// RQ1 - Reset input low holds device, execution suspended (code holds while RESET is high)
// RQ2 - Reset release starts execution at reset vector
// RQ3 - Reset clears all state, clock multiplier included (code leaves the pin synchroniser flops without reset)
// RQ4 - Source holds reset 2 ms for multiplier lock
// RQ5 - Status word resets to zero, backup bits undefined
// RQ6 - Master mode fetches first from 7FFF_FFF0
// RQ7 - Slave mode waits for break or interrupt
// RQ8 - Slave break input starts execution at 0000_0010
// RQ9 - Slave interrupt input starts execution at 0000_0080
// RQ10 - Port data resets to zero, bit0 follows pin
// RQ11 - Lock control register resets to zero
// RQ12 - Two ports, each direction individually selectable
// RQ13 - Internal clock runs four times input clock
// RQ14 - Strap high selects master, low selects slave
// RQ15 - Reset release synchronised to internal clock
// =====================================================================
package rsc_pkg;

   // =====================================================================
   // Register offsets (byte addresses, one 32-bit word each)
   localparam logic [7:0]  OFS_STATUS     = 8'h00;
   localparam logic [7:0]  OFS_FETCH_ADDR = 8'h04;
   localparam logic [7:0]  OFS_PSW        = 8'h08;
   localparam logic [7:0]  OFS_PORT_DIR   = 8'h0c;
   localparam logic [7:0]  OFS_PORT0_DATA = 8'h10;
   localparam logic [7:0]  OFS_PORT1_DATA = 8'h14;
   localparam logic [7:0]  OFS_MEM_LOCK   = 8'h18;
   localparam logic [7:0]  OFS_CLK_PERIOD = 8'h1c;

   // =====================================================================
   // Reset values and field positions
   localparam logic [31:0] PSW_RESET      = 32'h0000_0000;
   localparam int          PSW_BSM_POS    = 15;
   localparam int          PSW_BIE_POS    = 14;
   localparam int          PSW_BC_POS     = 8;
   localparam logic [7:0]  PORT_DATA_RESET = 8'h00;
   localparam logic [7:0]  MEM_LOCK_RESET = 8'h00;
   localparam logic [1:0]  PORT_DIR_RESET = 2'h0;
   localparam int          STAT_RUN_POS    = 0;
   localparam int          STAT_WAIT_POS   = 1;
   localparam int          STAT_MASTER_POS = 2;
   localparam int          STAT_LOCK_POS   = 3;
   localparam int          STAT_STATE_LSB  = 8;

   // =====================================================================
   // Start addresses
   localparam logic [31:0] VEC_MASTER     = 32'h7fff_fff0;
   localparam logic [31:0] VEC_BREAK      = 32'h0000_0010;
   localparam logic [31:0] VEC_INTERRUPT  = 32'h0000_0080;

   // =====================================================================
   // Clock multiplier
   localparam int          MULT_FACTOR    = 4;
   localparam int          MULT_SHIFT     = 2;
   localparam int          PERIOD_W       = 16;
   localparam int          LOCK_PERIODS   = 8;
   localparam int          MIN_PERIOD     = 8;

   // =====================================================================
   // Sequencer states
   typedef enum logic [4:0] {
      RSC_ST_HELD  = 5'b00001,
      RSC_ST_STRAP = 5'b00010,
      RSC_ST_LOCK  = 5'b00100,
      RSC_ST_WAIT  = 5'b01000,
      RSC_ST_RUN   = 5'b10000
   } rsc_state_e;

endpackage

// ### logic/rsc_clock_mult.sv
// Digital times-four clock multiplier: measures input period, ticks four times per period
`timescale 1ns/10ps
`default_nettype none
module rsc_clock_mult
   import rsc_pkg::*;
#(
   parameter int PW        = PERIOD_W,
   parameter int LOCK_CNT  = LOCK_PERIODS
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          clk_in_s,
   output logic              tick,
   output logic              locked,
   output logic [PW-1:0]     period
);

   if (PW < 8 || LOCK_CNT < 1 || LOCK_CNT > 255) begin : g_bad_params
      $error("rsc_clock_mult: unsupported parameters");
   end

   logic            in_d;
   logic [PW-1:0]   cnt;
   logic [PW-1:0]   phase;
   logic [7:0]      stable;
   logic [PW-1:0]   next_cnt;
   logic [PW-1:0]   next_phase;
   logic [7:0]      next_stable;
   logic [PW-1:0]   next_period;
   logic            next_tick;
   logic            next_locked;
   logic            rise;
   logic [PW-1:0]   quarter;
   logic [PW-1:0]   diff;

   assign rise    = clk_in_s & ~in_d;
   assign quarter = period >> MULT_SHIFT;

   // =====================================================================
   // Period measurement and tick generation
   always_comb begin
      next_cnt    = (cnt == {PW{1'b1}}) ? cnt : cnt + 1'b1;
      next_period = period;
      next_stable = stable;
      next_phase  = phase + 1'b1;
      next_tick   = 1'b0;
      next_locked = locked;
      diff        = (cnt > period) ? cnt - period : period - cnt;
      if (rise) begin
         next_cnt    = {{(PW-1){1'b0}}, 1'b1};
         next_period = cnt;
         next_phase  = {{(PW-1){1'b0}}, 1'b1};
         next_tick   = locked;
         // A drifting or too fast input restarts the lock count
         if (diff > 1 || cnt < PW'(MIN_PERIOD)) begin
            next_stable = 8'h00;
            next_locked = 1'b0;
         end else if (stable != 8'(LOCK_CNT)) begin
            next_stable = stable + 8'h01;
         end else begin
            next_locked = 1'b1;
         end
      end else if (phase >= quarter) begin
         next_phase = {{(PW-1){1'b0}}, 1'b1};
         next_tick  = locked; // RQ13
      end
      // A stopped input clock drops lock
      if (cnt == {PW{1'b1}}) begin
         next_locked = 1'b0;
         next_stable = 8'h00;
      end
      // No tick leaves in the cycle that lock is lost
      next_tick = next_tick & next_locked;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin // RQ3
         in_d   <= 1'b0;
         cnt    <= '0;
         phase  <= '0;
         stable <= 8'h00;
         period <= '0;
         tick   <= 1'b0;
         locked <= 1'b0;
      end else begin
         in_d   <= clk_in_s;
         cnt    <= next_cnt;
         phase  <= next_phase;
         stable <= next_stable;
         period <= next_period;
         tick   <= next_tick;
         locked <= next_locked;
      end
   end

endmodule
`default_nettype wire

// ### logic/rsc_reset_startup.sv
// Reset and start-up controller: reset sequencing, start address, ports, status word
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module rsc_reset_startup
   import rsc_pkg::*;
#(
   parameter int NUM_PORTS = 2,
   parameter int PW        = PERIOD_W,
   parameter int LOCK_CNT  = LOCK_PERIODS
) (
   input  wire logic          CLK,
   input  wire logic          RESET,
   input  wire logic          PSEL,
   input  wire logic          PENABLE,
   input  wire logic          PWRITE,
   input  wire logic [7:0]    PADDR,
   input  wire logic [31:0]   PWDATA,
   output logic [31:0]        PRDATA,
   output logic               PREADY,
   output logic               PSLVERR,
   input  wire logic          INPUT_CLOCK_PIN,
   input  wire logic          MASTER_MODE,
   input  wire logic          SYSTEM_BREAK_INPUT_N,
   input  wire logic          EXT_INT_N,
   input  wire logic [NUM_PORTS-1:0] PROG_PORT_IN,
   output logic [NUM_PORTS-1:0] PROG_PORT_OUT,
   output logic [NUM_PORTS-1:0] PROG_PORT_OE,
   output logic               RUN,
   output logic               FETCH_START,
   output logic [31:0]        FETCH_ADDR,
   output logic               INT_CLK_TICK,
   output logic               CLK_LOCKED,
   output logic               HOLD_EXCL_LOCK
);

   if (NUM_PORTS != 2) begin : g_bad_ports
      $error("rsc_reset_startup: exactly two programmable ports are supported");
   end

   localparam int NSYNC = 4 + NUM_PORTS;

   // =====================================================================
   // Reset synchroniser: assert at once, release on a clock edge
   logic [1:0]   rst_sync;
   logic         rst_int;

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin // RQ1
         rst_sync <= 2'b11;
      end else begin
         rst_sync <= {rst_sync[0], 1'b0}; // RQ15
      end
   end

   assign rst_int = rst_sync[1];

   // =====================================================================
   // Pin synchronisers; stage one feeds only stage two
   logic [NSYNC-1:0] pin_meta;
   logic [NSYNC-1:0] pin_s;
   logic [NSYNC-1:0] pin_raw;

   assign pin_raw = {PROG_PORT_IN, EXT_INT_N, SYSTEM_BREAK_INPUT_N, MASTER_MODE,
                     INPUT_CLOCK_PIN};

   // No reset: the strap and pins must already be settled when the sequencer
   // samples them just after release
   always_ff @(posedge CLK) begin
      pin_meta <= pin_raw;
      pin_s    <= pin_meta;
   end

   logic                 clk_in_s;
   logic                 strap_s;
   logic                 break_active;
   logic                 int_active;
   logic [NUM_PORTS-1:0] port_pin_s;

   assign clk_in_s     = pin_s[0];
   assign strap_s      = pin_s[1];
   assign break_active = ~pin_s[2];
   assign int_active   = ~pin_s[3];
   assign port_pin_s   = pin_s[NSYNC-1:4];

   // =====================================================================
   // Clock multiplier
   logic [PW-1:0] clk_period;

   rsc_clock_mult #(
      .PW       (PW),
      .LOCK_CNT (LOCK_CNT)
   ) u_mult (
      .clk      (CLK),
      .rst      (rst_int),
      .clk_in_s (clk_in_s),
      .tick     (INT_CLK_TICK),
      .locked   (CLK_LOCKED),
      .period   (clk_period)
   );

   // =====================================================================
   // Start-up sequencer
   rsc_state_e   state;
   rsc_state_e   next_state;
   logic         master;
   logic         next_master;
   logic [31:0]  next_fetch_addr;
   logic         next_fetch_start;

   always_comb begin
      next_state       = state;
      next_master      = master;
      next_fetch_addr  = FETCH_ADDR;
      next_fetch_start = 1'b0;
      unique case (state)
         RSC_ST_HELD: begin
            next_state = RSC_ST_STRAP; // RQ2
         end
         RSC_ST_STRAP: begin
            // Strap is sampled after release, once the synchroniser has settled
            next_master = strap_s; // RQ14
            next_state  = RSC_ST_LOCK;
         end
         RSC_ST_LOCK: begin
            // No fetch until the multiplied clock is stable
            if (CLK_LOCKED) begin
               if (master) begin
                  next_state       = RSC_ST_RUN;
                  next_fetch_addr  = VEC_MASTER; // RQ6
                  next_fetch_start = 1'b1;
               end else begin
                  next_state = RSC_ST_WAIT; // RQ7
               end
            end
         end
         RSC_ST_WAIT: begin
            // Break has priority when both arrive together
            if (break_active) begin
               next_state       = RSC_ST_RUN;
               next_fetch_addr  = VEC_BREAK; // RQ8
               next_fetch_start = 1'b1;
            end else if (int_active) begin
               next_state       = RSC_ST_RUN;
               next_fetch_addr  = VEC_INTERRUPT; // RQ9
               next_fetch_start = 1'b1;
            end
         end
         RSC_ST_RUN: begin
            next_state = RSC_ST_RUN;
         end
         default: begin
            next_state = RSC_ST_HELD;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge rst_int) begin
      if (rst_int) begin // RQ1
         state       <= RSC_ST_HELD;
         master      <= 1'b0;
         FETCH_ADDR  <= VEC_MASTER;
         FETCH_START <= 1'b0;
      end else begin
         state       <= next_state;
         master      <= next_master;
         FETCH_ADDR  <= next_fetch_addr;
         FETCH_START <= next_fetch_start;
      end
   end

   assign RUN = (state == RSC_ST_RUN);

   // =====================================================================
   // APB register file
   function automatic logic [3:0] reg_sel(input logic [7:0] addr);
      logic [3:0] sel;
      sel = 4'hf;
      if (addr[1:0] == 2'b00) begin
         unique case (addr)
            OFS_STATUS:     sel = 4'h0;
            OFS_FETCH_ADDR: sel = 4'h1;
            OFS_PSW:        sel = 4'h2;
            OFS_PORT_DIR:   sel = 4'h3;
            OFS_PORT0_DATA: sel = 4'h4;
            OFS_PORT1_DATA: sel = 4'h5;
            OFS_MEM_LOCK:   sel = 4'h6;
            OFS_CLK_PERIOD: sel = 4'h7;
            default:        sel = 4'hf;
         endcase
      end
      return sel;
   endfunction

   logic [31:0]          processor_status_word;
   logic [31:0]          next_psw;
   logic [NUM_PORTS-1:0] port_dir;
   logic [NUM_PORTS-1:0] next_port_dir;
   logic [7:0]           port_data [NUM_PORTS];
   logic [7:0]           next_port_data [NUM_PORTS];
   logic [7:0]           mem_lock;
   logic [7:0]           next_mem_lock;
   logic [7:0]           port_view [NUM_PORTS];
   logic [31:0]          next_prdata;
   logic                 next_pslverr;
   logic                 wr_en;
   logic [3:0]           sel;

   assign sel    = reg_sel(PADDR);
   assign wr_en  = PSEL & PENABLE & PWRITE;
   assign PREADY = 1'b1;

   // Bit 0 shows the pin while the port is an input, the latch while an output
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
         assign port_view[gi]     = {port_data[gi][7:1],
                                     port_dir[gi] ? port_data[gi][0] : port_pin_s[gi]}; // RQ10
         assign PROG_PORT_OUT[gi] = port_data[gi][0];
         assign PROG_PORT_OE[gi]  = port_dir[gi]; // RQ12
      end
   endgenerate

   always_comb begin
      next_psw      = processor_status_word;
      next_port_dir = port_dir;
      next_mem_lock = mem_lock;
      for (int i = 0; i < NUM_PORTS; i++) begin
         next_port_data[i] = port_data[i];
      end
      if (wr_en) begin
         unique case (sel)
            4'h2:    next_psw      = PWDATA;
            4'h3:    next_port_dir = PWDATA[NUM_PORTS-1:0]; // RQ12
            4'h4:    next_port_data[0] = PWDATA[7:0];
            4'h5:    next_port_data[1] = PWDATA[7:0];
            4'h6:    next_mem_lock = PWDATA[7:0];
            default: next_psw      = processor_status_word;
         endcase
      end
   end

   always_comb begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      unique case (sel)
         4'h0: begin
            next_prdata[STAT_RUN_POS]    = RUN;
            next_prdata[STAT_WAIT_POS]   = (state == RSC_ST_WAIT);
            next_prdata[STAT_MASTER_POS] = master;
            next_prdata[STAT_LOCK_POS]   = CLK_LOCKED;
            next_prdata[STAT_STATE_LSB +: 5] = state;
         end
         4'h1:    next_prdata = FETCH_ADDR;
         4'h2:    next_prdata = processor_status_word;
         4'h3:    next_prdata[NUM_PORTS-1:0] = port_dir;
         4'h4:    next_prdata[7:0] = port_view[0];
         4'h5:    next_prdata[7:0] = port_view[1];
         4'h6:    next_prdata[7:0] = mem_lock;
         4'h7:    next_prdata[PW-1:0] = clk_period;
         default: next_pslverr = 1'b1;
      endcase
   end

   always_ff @(posedge CLK or posedge rst_int) begin
      if (rst_int) begin // RQ3
         processor_status_word      <= PSW_RESET; // RQ5
         port_dir <= PORT_DIR_RESET;
         mem_lock <= MEM_LOCK_RESET; // RQ11
         for (int i = 0; i < NUM_PORTS; i++) begin
            port_data[i] <= PORT_DATA_RESET; // RQ10
         end
      end else begin
         processor_status_word      <= next_psw;
         port_dir <= next_port_dir;
         mem_lock <= next_mem_lock;
         for (int i = 0; i < NUM_PORTS; i++) begin
            port_data[i] <= next_port_data[i];
         end
      end
   end

   // Read data is registered during setup so it is stable in the access phase
   always_ff @(posedge CLK or posedge rst_int) begin
      if (rst_int) begin
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         PRDATA  <= (PSEL & ~PENABLE & ~PWRITE) ? next_prdata : PRDATA;
         PSLVERR <= (PSEL & ~PENABLE) ? next_pslverr : PSLVERR;
      end
   end

   // Lock register value zero selects hold-request exclusive lock
   assign HOLD_EXCL_LOCK = (mem_lock == MEM_LOCK_RESET); // RQ11

endmodule
`default_nettype wire

// ### verification/rsc_reset_startup_properties.sv
// Port-level assertions of the reset and start-up controller, bound to its top
`timescale 1ns/10ps
`default_nettype none
module rsc_reset_startup_checker
   import rsc_pkg::*;
#(
   parameter int NUM_PORTS = 2
) (
   input  wire logic                 CLK,
   input  wire logic                 RESET,
   input  wire logic                 MASTER_MODE,
   input  wire logic                 SYSTEM_BREAK_INPUT_N,
   input  wire logic                 EXT_INT_N,
   input  wire logic [NUM_PORTS-1:0] PROG_PORT_OE,
   input  wire logic                 RUN,
   input  wire logic                 FETCH_START,
   input  wire logic [31:0]          FETCH_ADDR,
   input  wire logic                 INT_CLK_TICK,
   input  wire logic                 CLK_LOCKED,
   input  wire logic                 HOLD_EXCL_LOCK
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   // =====================================================================
   // Sequences
   sequence s_released;
      $fell(RESET);
   endsequence
   // Three quiet samples cover the two-flop synchroniser plus the state update
   sequence s_slave_quiet;
      (!MASTER_MODE && !RUN && SYSTEM_BREAK_INPUT_N && EXT_INT_N) [*3];
   endsequence
   sequence s_slave_ready;
      !MASTER_MODE && CLK_LOCKED && !RUN;
   endsequence
   // =====================================================================
   // Properties
   property p_release_held;
      s_released |-> !RUN && !FETCH_START ##1 !RUN;
   endproperty
   property p_start_pulse;
      FETCH_START |-> RUN ##1 (RUN && !FETCH_START);
   endproperty
   property p_run_holds;
      RUN |=> RUN && $stable(FETCH_ADDR);
   endproperty
   property p_master_vec;
      FETCH_START && MASTER_MODE |-> FETCH_ADDR == VEC_MASTER;
   endproperty
   property p_slave_quiet;
      s_slave_quiet |=> !FETCH_START;
   endproperty
   property p_slave_brk;
      s_slave_ready and !SYSTEM_BREAK_INPUT_N |->
         ##[1:6] (FETCH_START && FETCH_ADDR == VEC_BREAK);
   endproperty
   property p_slave_int;
      s_slave_ready and (SYSTEM_BREAK_INPUT_N && !EXT_INT_N) |->
         ##[1:6] (FETCH_START && FETCH_ADDR == VEC_INTERRUPT);
   endproperty
   property p_tick_locked;
      INT_CLK_TICK |-> CLK_LOCKED;
   endproperty
   property p_lock_rst;
      s_released |-> HOLD_EXCL_LOCK;
   endproperty
   property p_dir_rst;
      s_released |-> PROG_PORT_OE == '0;
   endproperty
   a_release_held: assert property (p_release_held) else $error("run left reset early");
   a_start_pulse:  assert property (p_start_pulse) else $error("start pulse malformed");
   a_run_holds:    assert property (p_run_holds) else $error("run or start address moved");
   a_master_vec:   assert property (p_master_vec) else $error("master start address");
   a_slave_quiet:  assert property (p_slave_quiet) else $error("slave started unasked");
   a_slave_brk:    assert property (p_slave_brk) else $error("break start missing");
   a_slave_int:    assert property (p_slave_int) else $error("interrupt start missing");
   a_tick_locked:  assert property (p_tick_locked) else $error("tick while unlocked");
   a_lock_rst:     assert property (p_lock_rst) else $error("lock mode after reset");
   a_dir_rst:      assert property (p_dir_rst) else $error("port driven after reset");
endmodule

bind rsc_reset_startup rsc_reset_startup_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (
   .CLK, .RESET, .MASTER_MODE, .SYSTEM_BREAK_INPUT_N, .EXT_INT_N, .PROG_PORT_OE,
   .RUN, .FETCH_START, .FETCH_ADDR, .INT_CLK_TICK, .CLK_LOCKED, .HOLD_EXCL_LOCK
);
`default_nettype wire

// ### verification/rsc_board_model.sv
// Board model: external input clock source that feeds the controller's multiplier
`timescale 1ns/10ps
`default_nettype none
module rsc_board_model #(
   parameter int HALF = 6
) (
   input  wire logic clk,
   input  wire logic en,
   output logic      clk_pin
);
   int   cnt   = 0;
   logic pin_q = 1'h0;
   assign clk_pin = pin_q;
   // Oscillator stands low while the board holds it off, as during reset
   always @(posedge clk) begin
      if (!en) begin
         cnt <= 0;
         pin_q <= 1'h0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         pin_q <= !pin_q;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule
`default_nettype wire

// ### verification/rsc_reset_startup_tb_top.sv
// Self-checking testbench of the reset and start-up controller
`timescale 1ns/10ps
`default_nettype none
module rsc_reset_startup_tb_top;
   import rsc_pkg::*;
   logic        clk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, fetch_addr, rd;
   logic        pready, pslverr, in_clk, er, board_en = 1'h0, master_mode = 1'h1;
   logic        brk_n = 1'h1, int_n = 1'h1, run, fetch_start, tick, locked, hold_lock;
   logic [1:0]  port_in = 2'h1, port_out, port_oe;
   int          err_count = 0, samples_checked = 0;

   always #2.5 clk = ~clk;

   rsc_board_model #(.HALF(6)) u_board (.clk(clk), .en(board_en), .clk_pin(in_clk));
   // Short lock count keeps the start-up waits brief
   rsc_reset_startup #(.LOCK_CNT(2)) uut (
      .CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .INPUT_CLOCK_PIN(in_clk), .MASTER_MODE(master_mode), .SYSTEM_BREAK_INPUT_N(brk_n),
      .EXT_INT_N(int_n), .PROG_PORT_IN(port_in), .PROG_PORT_OUT(port_out),
      .PROG_PORT_OE(port_oe), .RUN(run), .FETCH_START(fetch_start), .FETCH_ADDR(fetch_addr),
      .INT_CLK_TICK(tick), .CLK_LOCKED(locked), .HOLD_EXCL_LOCK(hold_lock));

   // =====================================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s is %h, expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask

   task automatic do_reset;
      reset <= 1'h1;
      board_en <= 1'h0;
      repeat (16) @(posedge clk);
      check({29'h0, run, fetch_start, locked}, 32'h0, "outputs in reset");
      reset <= 1'h0;
      board_en <= 1'h1;
      repeat (3) @(posedge clk);
   endtask

   task automatic wait_start;
      int n;
      n = 0;
      while (fetch_start !== 1'h1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      check({31'h0, fetch_start}, 32'h1, "start pulse seen");
   endtask

   task automatic slave_go(input logic use_brk);
      int n;
      master_mode <= 1'h0;
      do_reset();
      n = 0;
      while (locked !== 1'h1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      check({31'h0, locked}, 32'h1, "multiplier locked");
      repeat (20) @(posedge clk);
      check({31'h0, run}, 32'h0, "slave idle");
      if (use_brk) begin
         brk_n <= 1'h0;
      end else begin
         int_n <= 1'h0;
      end
      wait_start();
      brk_n <= 1'h1;
      int_n <= 1'h1;
   endtask

   // =====================================================================
   // Scenarios
   task automatic t_master;
      int cnt;
      master_mode <= 1'h1;
      do_reset();
      wait_start();
      check(fetch_addr, VEC_MASTER, "master start");
      check({31'h0, run}, 32'h1, "run at start");
      @(posedge clk);
      check({31'h0, fetch_start}, 32'h0, "start pulse");
      @(posedge in_clk);
      @(posedge clk);
      cnt = 0;
      for (int i = 0; i < 48; i++) begin
         if (tick === 1'h1) cnt++;
         @(posedge clk);
      end
      check(cnt, MULT_FACTOR * 4, "ticks in four periods");
      apb(1'h0, OFS_STATUS, 32'h0);
      check(rd, 32'h0000_100d, "status: run, master, locked");
      apb(1'h0, OFS_FETCH_ADDR, 32'h0);
      check(rd, VEC_MASTER, "start address register");
      apb(1'h0, OFS_CLK_PERIOD, 32'h0);
      check(rd, 32'h0000_000c, "measured input period");
      apb(1'h1, OFS_PSW, 32'hffff_ffff);
      apb(1'h0, OFS_PSW, 32'h0);
      check(rd, 32'hffff_ffff, "status word written");
      apb(1'h1, OFS_MEM_LOCK, 32'h5);
      apb(1'h1, OFS_PORT_DIR, 32'h3);
      check({31'h0, hold_lock}, 32'h0, "shared lock mode");
      $display("done: master start");
   endtask

   task automatic t_reset_clear;
      do_reset();
      apb(1'h0, OFS_PSW, 32'h0);
      check(rd, PSW_RESET, "status word");
      apb(1'h0, OFS_MEM_LOCK, 32'h0);
      check(rd, 32'h0, "lock control");
      check({31'h0, hold_lock}, 32'h1, "exclusive lock");
      apb(1'h0, OFS_PORT_DIR, 32'h0);
      check(rd, 32'h0, "port direction");
      check({30'h0, port_oe}, 32'h0, "port enables");
      apb(1'h0, OFS_PORT0_DATA, 32'h0);
      check(rd, 32'h1, "port0 data");
      apb(1'h0, OFS_PORT1_DATA, 32'h0);
      check(rd, 32'h0, "port1 data");
      apb(1'h0, 8'h40, 32'h0);
      check({31'h0, er}, 32'h1, "unmapped error");
      $display("done: reset clears state");
   endtask

   task automatic t_ports;
      apb(1'h1, OFS_PORT_DIR, 32'h2);
      check({30'h0, port_oe}, 32'h2, "port1 output only");
      apb(1'h1, OFS_PORT1_DATA, 32'h1);
      check({31'h0, port_out[1]}, 32'h1, "port1 pin");
      apb(1'h0, OFS_PORT1_DATA, 32'h0);
      check(rd, 32'h1, "port1 readback");
      port_in <= 2'h0;
      repeat (4) @(posedge clk);
      apb(1'h0, OFS_PORT0_DATA, 32'h0);
      check(rd, 32'h0, "port0 follows pin");
      $display("done: port directions");
   endtask

   task automatic t_slave_break;
      slave_go(1'h1);
      check(fetch_addr, VEC_BREAK, "break start");
      $display("done: slave break");
   endtask

   task automatic t_slave_int;
      slave_go(1'h0);
      check(fetch_addr, VEC_INTERRUPT, "interrupt start");
      $display("done: slave interrupt");
   endtask

   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      t_master();
      t_reset_clear();
      t_ports();
      t_slave_break();
      t_slave_int();
      final_report();
   end

   // A hang anywhere above ends the run here, after 20000 clocks, counted as a failure
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      final_report();
   end
endmodule
`default_nettype wire
